// >>> src/gsp_consts.vh
// constants for the axis group stop, pause and add-axis command block
//
// Operation
// - group index latched on trigger rising edge only
// - group stop touches interpolated motion only
// - stop rising edge halts, aborts buffered segments
// - stop done when halted, axes stay synchronized
// - stop held high rejects new path commands
// - stop falling edge releases group to state_a
// - method 0 ramps down, 1 halts at once
// - retrigger during ramp uses new deceleration
// - second stop on same group raises error
// - pause holds while its enable stays high
// - pause touches interpolated motion only
// - paused state_a group syncs but never runs
// - pause ramps down, done, segment stays active
// - path commands during pause stay buffered
// - pause falling edge resumes paused segment
// - pause retrigger during ramp uses new rate
// - second pause aborts first, uses its rate
// - add axis 0-63 to slot 0-7, done
// - trigger low keeps membership unchanged
// - slot 0..7 means X Y Z A B C H W
// - segment buffer holds eight entries per group
`ifndef GSP_CONSTS_VH
`define GSP_CONSTS_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define GSP_OFF_CTRL 8'h00
`define GSP_OFF_SCFG0 8'h04
`define GSP_OFF_SCFG1 8'h08
`define GSP_OFF_PCFG0 8'h0C
`define GSP_OFF_PCFG1 8'h10
`define GSP_OFF_ADD 8'h14
`define GSP_OFF_PATH 8'h18
`define GSP_OFF_STAT 8'h1C
`define GSP_OFF_GSTAT 8'h20
`define GSP_OFF_QCNT 8'h24
`define GSP_OFF_MEMB 8'h28
`define GSP_OFF_ERRC 8'h2C
`define GSP_OFF_SPEED 8'h30
// ---------------------------------------------------------------
// control bits (trigger levels) and field positions
// ---------------------------------------------------------------
`define GSP_CTRL_W 6
`define GSP_BIT_PATH 5
`define GSP_BIT_ADD 4
`define GSP_METH_BIT 4
`define GSP_SLOT_LSB 8
`define GSP_AXIS_LSB 16
`define GSP_RATE_LSB 16
// ---------------------------------------------------------------
// command states and stop methods
// ---------------------------------------------------------------
`define GSP_ST_IDLE 2'h0
`define GSP_ST_BUSY 2'h1
`define GSP_ST_DONE 2'h2
`define GSP_ST_FAIL 2'h3
`define GSP_METH_RAMP 1'h0
`define GSP_METH_NOW 1'h1
// ---------------------------------------------------------------
// error codes, buffer depth, segment time, slot roles
// ---------------------------------------------------------------
`define GSP_ERR_NONE 16'h0000
`define GSP_ERR_MULTI 16'h0001
`define GSP_ERR_STOPPED 16'h0002
`define GSP_ERR_FULL 16'h0003
`define GSP_QDEPTH 4'h8
`define GSP_SEG_LEN 16'h0040
`define GSP_SLOT_X 3'h0
`define GSP_SLOT_Y 3'h1
`define GSP_SLOT_Z 3'h2
`define GSP_SLOT_A 3'h3
`define GSP_SLOT_B 3'h4
`define GSP_SLOT_C 3'h5
`define GSP_SLOT_H 3'h6
`define GSP_SLOT_W 3'h7
`endif

// >>> src/gsp_edge.v
// rising and falling edge detector for trigger levels
`timescale 1ns/10ps
`default_nettype none
module gsp_edge #(
    parameter W = 6
) (
    input wire clk, // system clock
    input wire rst_b, // async reset, active low
    input wire [W-1:0] sig, // trigger levels
    output wire [W-1:0] rise, // one-cycle rising pulse
    output wire [W-1:0] fall // one-cycle falling pulse
);
    reg [W-1:0] prev_reg; // level seen last cycle

    // remember last level
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_reg <= {W{1'b0}};
        end else begin
            prev_reg <= sig;
        end
    end

    assign rise = sig & ~prev_reg;
    assign fall = ~sig & prev_reg;
endmodule // gsp_edge
`default_nettype wire

// >>> src/gsp_group.v
// one axis group: segment buffer, speed ramp, stop and pause hold
`timescale 1ns/10ps
`default_nettype none
`include "gsp_consts.vh"
module gsp_group #(
    parameter SEG_LEN = `GSP_SEG_LEN
) (
    input wire clk, // system clock
    input wire rst_b, // async reset, active low
    input wire stop_req, // a stop command holds this group
    input wire stop_now, // stop without ramp
    input wire pause_req, // a pause command holds this group
    input wire [15:0] decel, // speed drop per cycle
    input wire push, // accepted path segment
    input wire [15:0] push_spd, // segment speed
    output wire [15:0] speed, // interpolator speed
    output wire [3:0] qcnt, // buffered segments
    output wire sync, // axes in synchronized motion
    output wire halted // speed is zero
);
    reg [15:0] spd_reg; // current speed
    reg [15:0] tgt_reg; // segment speed
    reg [15:0] seg_reg; // cycles left in running segment
    reg [3:0] cnt_reg; // queue fill
    reg run_reg; // a segment is running
    reg sync_reg; // axis state, 0 means state_a
    reg stop_prev_reg; // stop level last cycle
    wire hold = stop_req | pause_req; // interpolation frozen
    wire s_rise = stop_req & ~stop_prev_reg;
    wire s_fall = ~stop_req & stop_prev_reg;
    wire pop = ~run_reg & (cnt_reg != 4'h0) & ~hold;
    wire seg_end = run_reg & ~hold & (seg_reg == 16'h0001);

    // speed ramp: hold ramps down, stop_now drops to zero at once, running segment goes to target
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            spd_reg <= 16'h0000;
        end else if (stop_req && stop_now) begin
            spd_reg <= 16'h0000;
        end else if (hold) begin
            spd_reg <= (spd_reg > decel) ? spd_reg - decel : 16'h0000;
        end else if (run_reg && !seg_end) begin
            spd_reg <= tgt_reg;
        end else begin
            spd_reg <= 16'h0000;
        end
    end

    // segment buffer and sequencing
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 4'h0;
            run_reg <= 1'b0;
            seg_reg <= 16'h0000;
            tgt_reg <= 16'h0000;
            sync_reg <= 1'b0;
            stop_prev_reg <= 1'b0;
        end else begin
            stop_prev_reg <= stop_req;
            if (s_rise) begin
                cnt_reg <= 4'h0;
            end else if (s_fall) begin
                cnt_reg <= 4'h0;
                run_reg <= 1'b0;
                sync_reg <= 1'b0;
            end else begin
                if (push) begin
                    tgt_reg <= push_spd;
                    sync_reg <= 1'b1;
                end
                // buffered while held, never more than eight
                cnt_reg <= cnt_reg + {3'h0, push} - {3'h0, pop};
                if (pop) begin
                    run_reg <= 1'b1;
                    seg_reg <= SEG_LEN[15:0]; // segment length cut to the counter width
                end else if (seg_end) begin
                    run_reg <= 1'b0;
                    if (cnt_reg == 4'h0 && !push) begin
                        sync_reg <= 1'b0;
                    end
                end else if (run_reg && !hold) begin
                    seg_reg <= seg_reg - 16'h0001;
                end
            end
        end
    end

    assign speed = spd_reg;
    assign qcnt = cnt_reg;
    assign sync = sync_reg;
    assign halted = (spd_reg == 16'h0000);
endmodule // gsp_group
`default_nettype wire

// >>> src/gsp_top.v
// group stop, group pause and add-axis command logic with APB registers
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "gsp_consts.vh"
module gsp_top #(
    parameter NG = 8, // groups
    parameter SEG_LEN = `GSP_SEG_LEN // cycles per path segment
) (
    input wire clk, // system clock, 100 MHz
    input wire rst_b, // async reset, active low
    input wire [7:0] paddr, // APB address
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB write
    input wire [31:0] pwdata, // APB write data
    output wire [31:0] prdata, // APB read data
    output wire pready, // APB ready
    output wire pslverr, // APB error on unmapped address
    output wire [NG*16-1:0] grp_speed, // interpolator speed per group
    output wire [NG-1:0] grp_sync, // axes synchronized per group
    output wire [NG-1:0] grp_hold // interpolator held per group
);
    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    // command active on group g
    function gsp_on;
        input act;
        input [2:0] grp;
        input [2:0] g;
        begin
            gsp_on = act && (grp == g);
        end
    endfunction

    // ---------------------------------------------------------------
    // register storage
    // ---------------------------------------------------------------
    reg [`GSP_CTRL_W-1:0] ctrl_reg; // trigger levels
    reg [31:0] scfg0_reg; // stop 0: group, method, rate
    reg [31:0] scfg1_reg; // stop 1
    reg [31:0] pcfg0_reg; // pause 0: group, rate
    reg [31:0] pcfg1_reg; // pause 1
    reg [31:0] add_reg; // add: group, slot, axis
    reg [31:0] path_reg; // path: group, speed
    reg [15:0] errc_reg; // last error code
    reg [31:0] rdata_reg; // read data caught at setup
    reg rerr_reg; // unmapped address at setup
    reg [6:0] memb_mem [0:63]; // {valid, axis} per group and slot
    reg [1:0] add_st_reg; // add command state
    reg [1:0] path_st_reg; // path command state
    reg [2:0] add_grp_reg; // latched add group
    reg [2:0] add_slot_reg; // latched add slot
    reg [5:0] add_axis_reg; // latched axis number
    reg [2:0] path_grp_reg; // latched path group
    wire [`GSP_CTRL_W-1:0] rise; // trigger rising pulses
    wire [`GSP_CTRL_W-1:0] fall; // trigger falling pulses
    wire [63:0] scfg_v = {scfg1_reg, scfg0_reg};
    wire [63:0] pcfg_v = {pcfg1_reg, pcfg0_reg};
    wire [1:0] st_act; // stop instance holds its group
    wire [5:0] st_grp; // stop instance groups
    wire [1:0] st_meth; // stop instance methods
    wire [1:0] st_clash; // stop rejected by other stop
    wire [7:0] st_stat; // stop status nibbles
    wire [1:0] pa_act; // pause instance holds its group
    wire [5:0] pa_grp; // pause instance groups
    wire [7:0] pa_stat; // pause status nibbles
    wire [NG-1:0] g_stop; // stop level per group
    wire [NG-1:0] g_pause; // pause level per group
    wire [NG-1:0] g_halt; // speed zero per group
    wire [NG*4-1:0] g_qcnt; // queue fill per group
    wire wr = psel & penable & pwrite; // write takes effect
    wire [2:0] pgrp = path_reg[2:0];
    wire path_rej_stop = g_stop[pgrp];
    wire path_rej_full = (g_qcnt[pgrp*4 +: 4] == `GSP_QDEPTH);
    wire path_ok = rise[`GSP_BIT_PATH] & ~path_rej_stop & ~path_rej_full;

    // ---------------------------------------------------------------
    // trigger edges
    // ---------------------------------------------------------------
    gsp_edge #(
        .W(`GSP_CTRL_W)
    ) u_edge (
        .clk(clk),
        .rst_b(rst_b),
        .sig(ctrl_reg),
        .rise(rise),
        .fall(fall)
    );

    // ---------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------
    // register writes in the access phase
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= {`GSP_CTRL_W{1'b0}};
            scfg0_reg <= 32'h00000000;
            scfg1_reg <= 32'h00000000;
            pcfg0_reg <= 32'h00000000;
            pcfg1_reg <= 32'h00000000;
            add_reg <= 32'h00000000;
            path_reg <= 32'h00000000;
        end else if (wr) begin
            case (paddr)
                `GSP_OFF_CTRL: ctrl_reg <= pwdata[`GSP_CTRL_W-1:0];
                `GSP_OFF_SCFG0: scfg0_reg <= pwdata;
                `GSP_OFF_SCFG1: scfg1_reg <= pwdata;
                `GSP_OFF_PCFG0: pcfg0_reg <= pwdata;
                `GSP_OFF_PCFG1: pcfg1_reg <= pwdata;
                `GSP_OFF_ADD: add_reg <= pwdata;
                `GSP_OFF_PATH: path_reg <= pwdata;
                default: ctrl_reg <= ctrl_reg; // read-only or unmapped
            endcase
        end
    end

    // read data and error caught in the setup phase
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 32'h00000000;
            rerr_reg <= 1'b0;
        end else if (psel && !penable) begin
            rerr_reg <= 1'b0;
            case (paddr)
                `GSP_OFF_CTRL: rdata_reg <= {26'h0000000, ctrl_reg};
                `GSP_OFF_SCFG0: rdata_reg <= scfg0_reg;
                `GSP_OFF_SCFG1: rdata_reg <= scfg1_reg;
                `GSP_OFF_PCFG0: rdata_reg <= pcfg0_reg;
                `GSP_OFF_PCFG1: rdata_reg <= pcfg1_reg;
                `GSP_OFF_ADD: rdata_reg <= add_reg;
                `GSP_OFF_PATH: rdata_reg <= path_reg;
                `GSP_OFF_STAT: rdata_reg <= {8'h00, path_st_reg == `GSP_ST_FAIL, 1'b0, 1'b0,
                    path_st_reg == `GSP_ST_DONE, add_st_reg == `GSP_ST_FAIL, 1'b0,
                    add_st_reg == `GSP_ST_BUSY, add_st_reg == `GSP_ST_DONE, pa_stat, st_stat};
                `GSP_OFF_GSTAT: rdata_reg <= {g_stop, g_pause, g_halt, grp_sync};
                `GSP_OFF_QCNT: rdata_reg <= g_qcnt;
                `GSP_OFF_MEMB: rdata_reg <= {25'h0000000,
                    memb_mem[{add_reg[2:0], add_reg[`GSP_SLOT_LSB +: 3]}]};
                `GSP_OFF_ERRC: rdata_reg <= {16'h0000, errc_reg};
                `GSP_OFF_SPEED: rdata_reg <= {16'h0000, grp_speed[pgrp*16 +: 16]};
                default: begin
                    rdata_reg <= 32'h00000000;
                    rerr_reg <= 1'b1; // unmapped
                end
            endcase
        end
    end

    assign prdata = rdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel & penable & rerr_reg;

    // ---------------------------------------------------------------
    // group stop commands
    // ---------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1) begin : g_stop_cmd
            reg [1:0] st_reg; // command state
            reg [2:0] grp_reg; // latched group
            reg meth_reg; // latched method
            wire [31:0] cfg = scfg_v[k*32 +: 32];
            // another stop already running with trigger high on this group
            wire clash = gsp_on(st_act[1-k], st_grp[(1-k)*3 +: 3], cfg[2:0]);

            // stop state: busy while ramping, done when halted
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    st_reg <= `GSP_ST_IDLE;
                    grp_reg <= 3'h0;
                    meth_reg <= `GSP_METH_RAMP;
                end else if (fall[k]) begin
                    st_reg <= `GSP_ST_IDLE;
                end else if (rise[k]) begin
                    grp_reg <= cfg[2:0];
                    meth_reg <= cfg[`GSP_METH_BIT];
                    st_reg <= clash ? `GSP_ST_FAIL : `GSP_ST_BUSY;
                end else if (st_reg == `GSP_ST_BUSY && g_halt[grp_reg]) begin
                    st_reg <= `GSP_ST_DONE;
                end
            end

            assign st_act[k] = (st_reg == `GSP_ST_BUSY) || (st_reg == `GSP_ST_DONE);
            assign st_grp[k*3 +: 3] = grp_reg;
            assign st_meth[k] = meth_reg;
            assign st_clash[k] = rise[k] & clash;
            assign st_stat[k*4 +: 4] = {st_reg == `GSP_ST_FAIL, 1'b0,
                st_reg == `GSP_ST_BUSY, st_reg == `GSP_ST_DONE};
        end
    endgenerate

    // ---------------------------------------------------------------
    // group pause commands
    // ---------------------------------------------------------------
    generate
        for (k = 0; k < 2; k = k + 1) begin : g_pause_cmd
            reg [1:0] st_reg; // command state, FAIL means aborted
            reg [2:0] grp_reg; // latched group
            wire [31:0] ocfg = pcfg_v[(1-k)*32 +: 32];
            wire act = (st_reg == `GSP_ST_BUSY) || (st_reg == `GSP_ST_DONE);
            // the other pause newly triggered on this group takes over
            wire taken = rise[3-k] && act && (ocfg[2:0] == grp_reg);

            // pause state: level held, done once the ramp ends
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    st_reg <= `GSP_ST_IDLE;
                    grp_reg <= 3'h0;
                end else if (fall[2+k]) begin
                    st_reg <= `GSP_ST_IDLE;
                end else if (rise[2+k]) begin
                    grp_reg <= pcfg_v[k*32 +: 3];
                    st_reg <= `GSP_ST_BUSY;
                end else if (taken) begin
                    st_reg <= `GSP_ST_FAIL;
                end else if (st_reg == `GSP_ST_BUSY && g_halt[grp_reg]) begin
                    st_reg <= `GSP_ST_DONE;
                end
            end

            assign pa_act[k] = act;
            assign pa_grp[k*3 +: 3] = grp_reg;
            assign pa_stat[k*4 +: 4] = {1'b0, st_reg == `GSP_ST_FAIL,
                st_reg == `GSP_ST_BUSY, st_reg == `GSP_ST_DONE};
        end
    endgenerate

    // ---------------------------------------------------------------
    // add-axis and path commands
    // ---------------------------------------------------------------
    // add: one busy cycle, then membership written and done
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            add_st_reg <= `GSP_ST_IDLE;
            add_grp_reg <= 3'h0;
            add_slot_reg <= `GSP_SLOT_X;
            add_axis_reg <= 6'h00;
        end else if (fall[`GSP_BIT_ADD]) begin
            add_st_reg <= `GSP_ST_IDLE;
        end else if (rise[`GSP_BIT_ADD]) begin
            add_grp_reg <= add_reg[2:0];
            add_slot_reg <= add_reg[`GSP_SLOT_LSB +: 3];
            add_axis_reg <= add_reg[`GSP_AXIS_LSB +: 6];
            add_st_reg <= `GSP_ST_BUSY;
        end else if (add_st_reg == `GSP_ST_BUSY) begin
            add_st_reg <= `GSP_ST_DONE;
        end
    end

    // membership table, cleared at reset, kept when trigger drops
    integer i;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (i = 0; i < 64; i = i + 1) begin
                memb_mem[i] <= 7'h00;
            end
        end else if (add_st_reg == `GSP_ST_BUSY && !fall[`GSP_BIT_ADD]) begin
            memb_mem[{add_grp_reg, add_slot_reg}] <= {1'b1, add_axis_reg};
        end
    end

    // path command: accepted into buffer or refused
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            path_st_reg <= `GSP_ST_IDLE;
            path_grp_reg <= 3'h0;
        end else if (fall[`GSP_BIT_PATH]) begin
            path_st_reg <= `GSP_ST_IDLE;
        end else if (rise[`GSP_BIT_PATH]) begin
            path_grp_reg <= pgrp;
            path_st_reg <= path_ok ? `GSP_ST_DONE : `GSP_ST_FAIL;
        end
    end

    // last error code
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            errc_reg <= `GSP_ERR_NONE;
        end else if (|st_clash) begin
            errc_reg <= `GSP_ERR_MULTI;
        end else if (rise[`GSP_BIT_PATH] && path_rej_stop) begin
            errc_reg <= `GSP_ERR_STOPPED;
        end else if (rise[`GSP_BIT_PATH] && path_rej_full) begin
            errc_reg <= `GSP_ERR_FULL;
        end
    end

    // ---------------------------------------------------------------
    // groups; single-axis motion never passes through here
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NG; g = g + 1) begin : g_grp
            wire s0 = gsp_on(st_act[0], st_grp[2:0], g);
            wire s1 = gsp_on(st_act[1], st_grp[5:3], g);
            wire q0 = gsp_on(pa_act[0], pa_grp[2:0], g);
            wire q1 = gsp_on(pa_act[1], pa_grp[5:3], g);
            // live rate: stop before pause, newest pause only
            wire [15:0] rate = s1 ? scfg1_reg[`GSP_RATE_LSB +: 16] :
                s0 ? scfg0_reg[`GSP_RATE_LSB +: 16] :
                q1 ? pcfg1_reg[`GSP_RATE_LSB +: 16] :
                pcfg0_reg[`GSP_RATE_LSB +: 16];

            assign g_stop[g] = s0 | s1;
            assign g_pause[g] = q0 | q1;

            gsp_group #(
                .SEG_LEN(SEG_LEN)
            ) u_grp (
                .clk(clk),
                .rst_b(rst_b),
                .stop_req(g_stop[g]),
                .stop_now(s1 ? st_meth[1] : st_meth[0]),
                .pause_req(g_pause[g]),
                .decel(rate),
                .push(path_ok && (pgrp == g)),
                .push_spd(path_reg[`GSP_RATE_LSB +: 16]),
                .speed(grp_speed[g*16 +: 16]),
                .qcnt(g_qcnt[g*4 +: 4]),
                .sync(grp_sync[g]),
                .halted(g_halt[g])
            );
        end
    endgenerate

    assign grp_hold = g_stop | g_pause;
endmodule // gsp_top
`default_nettype wire

// >>> bench/gsp_top_chk.sv
// port assertions for the group stop, pause and add-axis block
`timescale 1ns/10ps
`default_nettype none
module gsp_top_chk #(
    parameter NG = 8, // groups
    parameter SEG_LEN = 64 // cycles per segment
) (
    input wire clk, // system clock
    input wire rst_b, // async reset, active low
    input wire [7:0] paddr, // apb address
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb write
    input wire [31:0] pwdata, // apb write data
    input wire [31:0] prdata, // apb read data
    input wire pready, // apb ready
    input wire pslverr, // apb error
    input wire [NG*16-1:0] grp_speed, // speed per group
    input wire [NG-1:0] grp_sync, // sync per group
    input wire [NG-1:0] grp_hold // hold per group
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // access phase of one transfer
    sequence s_acc;
        psel && penable;
    endsequence
    // group 0 held for three samples in a row
    sequence s_held;
        grp_hold[0] && $past(grp_hold[0]) && $past(grp_hold[0], 2);
    endsequence
    chk_ready_high: assert property (s_acc |-> pready) else $error("pready low in access");
    chk_err_phase: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    chk_err_unmapped: assert property (s_acc ##0 paddr > 8'h30 |-> pslverr) else $error("no error on unmapped");
    chk_err_mapped: assert property (s_acc ##0 (paddr <= 8'h30 && paddr[1:0] == 2'h0) |-> !pslverr)
        else $error("error on mapped register");
    chk_rdata_hold: assert property (s_acc |=> $stable(prdata)) else $error("read data moved after access");
    chk_unmapped_zero: assert property (s_acc ##0 (pslverr && !pwrite) |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_reset_idle: assert property ($rose(rst_b) |-> grp_speed == '0 && grp_sync == '0 && grp_hold == '0)
        else $error("group state not idle after reset");
    chk_hold_no_accel: assert property (s_held |-> grp_speed[15:0] <= $past(grp_speed[15:0]))
        else $error("held group speeds up");
endmodule // gsp_top_chk
bind gsp_top gsp_top_chk #(.NG(NG), .SEG_LEN(SEG_LEN)) i_gsp_top_chk(.clk(clk), .rst_b(rst_b), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .grp_speed(grp_speed), .grp_sync(grp_sync), .grp_hold(grp_hold));
`default_nettype wire

// >>> bench/gsp_axes_model.sv
// servo axes of group 0: position follows the interpolator speed
`timescale 1ns/10ps
`default_nettype none
module gsp_axes_model (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic [15:0] speed, // commanded speed
    output logic [31:0] pos // integrated position
);
    // axes move only by what the interpolator commands
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) pos <= 32'h0;
        else pos <= pos + {16'h0, speed};
    end
endmodule // gsp_axes_model
`default_nettype wire

// >>> bench/gsp_top_tb.sv
// self-checking bench for the group stop, pause and add-axis block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module gsp_top_tb;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, er; // apb controls
    logic [7:0] paddr = 8'h00; // apb address
    logic [31:0] pwdata = 32'h0, rd, p0; // write data, read back, saved position
    wire [31:0] prdata, pos; // read data, axis position
    wire pready, pslverr; // apb answer
    wire [127:0] grp_speed; // speed per group
    wire [7:0] grp_sync, grp_hold; // group flags
    int bad_count = 0, n_checks = 0, seed = 32'h292d, ax, prv, i;
    always #5 clk = ~clk;
    gsp_top #(.SEG_LEN(200)) i_gsp_top(.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .grp_speed(grp_speed), .grp_sync(grp_sync), .grp_hold(grp_hold));
    gsp_axes_model i_gsp_axes_model(.clk(clk), .rst_b(rst_b), .speed(grp_speed[15:0]), .pos(pos));
    // one apb transfer: setup, then access until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // write trigger levels and let the command state settle
    task ctl(input logic [31:0] d);
        apb(1, 8'h00, d);
        repeat (4) @(posedge clk);
        #1;
    endtask
    // model of the ramp: speed drops by the rate each cycle down to zero
    task ramp(input int d);
        repeat (2) @(posedge clk);
        #1;
        for (i = 0; i < 300 && grp_speed[15:0] !== 16'h0; i++) begin
            prv = grp_speed[15:0];
            @(posedge clk);
            #1;
            `CHK(grp_speed[15:0], 16'(prv > d ? prv - d : 0))
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #500000;
        bad_count++;
        wrap_up;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1;
        apb(0, 8'h20, 0); `CHK(rd, 32'h0000FF00)
        apb(0, 8'h44, 0);
        for (int s = 0; s < 8; s++) begin
            ax = $random(seed) & 63;
            apb(1, 8'h14, {10'h0, ax[5:0], 5'h0, s[2:0], 5'h0, s[2:0]});
            ctl(32'h10); apb(0, 8'h1C, 0); `CHK(rd[19:16], 4'h1)
            ctl(32'h0); apb(0, 8'h28, 0); `CHK(rd[6:0], {1'b1, ax[5:0]})
        end
        apb(1, 8'h18, 32'h0100_0000);
        repeat (10) begin ctl(32'h20); ctl(32'h0); end
        apb(0, 8'h2C, 0); `CHK(rd[15:0], 16'h3)
        apb(0, 8'h24, 0); `CHK(rd[3:0], 4'h8)
        apb(1, 8'h04, 32'h0010_0010); ctl(32'h1); `CHK(grp_speed[15:0], 16'h0)
        `CHK(grp_sync[0], 1'b1)
        p0 = pos;
        apb(0, 8'h24, 0); `CHK(rd[3:0], 4'h0)
        apb(0, 8'h1C, 0); `CHK(rd[3:0], 4'h1)
        ctl(32'h21); apb(0, 8'h1C, 0); `CHK(rd[23:20], 4'h8)
        apb(0, 8'h2C, 0); `CHK(rd[15:0], 16'h2)
        apb(1, 8'h08, 32'h0); ctl(32'h3); apb(0, 8'h1C, 0); `CHK(rd[7:4], 4'h8)
        apb(0, 8'h2C, 0); `CHK(rd[15:0], 16'h1)
        `CHK(pos, p0)
        ctl(32'h0); `CHK(grp_sync[0], 1'b0)
        ctl(32'h20); ctl(32'h0); repeat (40) @(posedge clk);
        apb(1, 8'h0C, 32'h0008_0000); ctl(32'h4); ramp(8);
        apb(0, 8'h1C, 0); `CHK(rd[11:8], 4'h1)
        `CHK(grp_sync[0], 1'b1)
        ctl(32'h24); apb(0, 8'h1C, 0); `CHK(rd[23:20], 4'h1)
        `CHK(grp_speed[15:0], 16'h0)
        apb(1, 8'h10, 32'h0004_0000); ctl(32'hC); apb(0, 8'h1C, 0); `CHK(rd[11:8], 4'h4)
        ctl(32'h0);
        for (i = 0; i < 100 && grp_speed[15:0] === 16'h0; i++) @(posedge clk);
        #1;
        `CHK(grp_speed[15:0] != 16'h0, 1'b1)
        apb(1, 8'h04, 32'h0020_0000); ctl(32'h1); ramp(32);
        apb(0, 8'h1C, 0); `CHK(rd[3:0], 4'h1)
        wrap_up;
    end
endmodule // gsp_top_tb
`default_nettype wire
